/* File: logic/ocp_regs.vh */
// Register map, field positions, reset values and timing counts for the option pin block
`ifndef OCP_REGS_VH
`define OCP_REGS_VH
// ***************************************************
// Register byte offsets
// ***************************************************
`define OCP_ADDR_CTRL     4'h0
`define OCP_ADDR_STATUS   4'h4
`define OCP_ADDR_CFG      4'h8
// ***************************************************
// Control register fields
// ***************************************************
`define OCP_BIT_USRCLK_EN 0
`define OCP_BIT_INIT_EN   1
`define OCP_BIT_OCT_GATE  2
`define OCP_BIT_OE_EN     3
`define OCP_BIT_CLR_EN    4
`define OCP_BIT_AS_TRI    5
`define OCP_BIT_UIO_OUT   8
`define OCP_BIT_UIO_OE    9
`define OCP_CTRL_RESET    10'h000
`define OCP_CTRL_MASK     10'h33F
// ***************************************************
// Config-event register fields (write one to pulse)
// ***************************************************
`define OCP_BIT_FRAME     0
`define OCP_BIT_LOADED    1
// ***************************************************
// Status register fields
// ***************************************************
`define OCP_ST_LSB        0
`define OCP_BIT_RESTART   8
`define OCP_BIT_CALDONE   9
`define OCP_BIT_CHIP_OE   10
`define OCP_BIT_CHIP_CLR  11
`define OCP_BIT_USER      12
// ***************************************************
// Timing and bus answers
// ***************************************************
`define OCP_INIT_TICKS    8'h10
`define OCP_RESP_OKAY     2'h0
`define OCP_RESP_DECERR   2'h3
`endif

/* File: logic/ocp_top.v */
// Optional configuration pin control with an AXI4-Lite register slave
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`include "ocp_regs.vh"
module ocp_top #(
  parameter [7:0] INIT_TICKS = `OCP_INIT_TICKS
) (
  // Clock and reset
  input  wire        clk_in,
  input  wire        rst_in,
  // AXI4-Lite write address and data
  input  wire [3:0]  s_axi_awaddr_in,
  input  wire        s_axi_awvalid_in,
  output reg         s_axi_awready_out,
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  input  wire        s_axi_wvalid_in,
  output reg         s_axi_wready_out,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp_out,
  output reg         s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  // AXI4-Lite read
  input  wire [3:0]  s_axi_araddr_in,
  input  wire        s_axi_arvalid_in,
  output reg         s_axi_arready_out,
  output reg  [31:0] s_axi_rdata_out,
  output reg  [1:0]  s_axi_rresp_out,
  output reg         s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  // Device pins
  input  wire        config_restart_n_in,
  input  wire        user_startup_clock_in,
  input  wire        termination_cal_done_in,
  input  wire        chip_output_enable_in,
  input  wire        chip_register_clear_n_in,
  input  wire        init_done_in,
  output reg         init_done_out,
  output reg         init_done_oe_out,
  output reg         init_done_pullup_out,
  // Chip-wide controls
  output reg         io_tristate_out,
  output reg         reg_clear_out,
  output reg         serial_pins_tristate_out,
  output reg         user_mode_out
);
  // ***************************************************
  // States
  // ***************************************************
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_CFG  = 6'h02;
  localparam [5:0] ST_LOAD = 6'h04;
  localparam [5:0] ST_INIT = 6'h08;
  localparam [5:0] ST_OCT  = 6'h10;
  localparam [5:0] ST_USER = 6'h20;

  reg  [5:0] state;
  reg  [5:0] next_state;
  reg  [9:0] ctrl;
  reg  [5:0] opt;
  reg  [7:0] ticks;
  reg        ev_frame;
  reg        ev_loaded;
  reg  [1:0] rst_sync;
  reg  [2:0] uclk_sync;
  reg  [1:0] cal_sync;
  reg  [1:0] oe_sync;
  reg  [1:0] clr_sync;
  reg  [1:0] pin_sync;
  reg        aw_held;
  reg  [3:0] aw_addr;
  reg        w_held;
  reg  [31:0] w_data;
  reg  [3:0] w_strb;
  wire       init_tick;
  wire       init_end;
  wire       drive_low;
  wire       wr_go;
  wire [3:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire [9:0] wr_masked;
  wire       chip_tri;
  wire       chip_clr;

  // ***************************************************
  // Pin synchronisers
  // ***************************************************
  always @(posedge clk_in) begin
    if (rst_in) begin
      rst_sync  <= 2'h0;
      uclk_sync <= 3'h0;
      cal_sync  <= 2'h0;
      oe_sync   <= 2'h3;
      clr_sync  <= 2'h3;
      pin_sync  <= 2'h3;
    end else begin
      rst_sync  <= {rst_sync[0], config_restart_n_in};
      uclk_sync <= {uclk_sync[1:0], user_startup_clock_in};
      cal_sync  <= {cal_sync[0], termination_cal_done_in};
      oe_sync   <= {oe_sync[0], chip_output_enable_in};
      clr_sync  <= {clr_sync[0], chip_register_clear_n_in};
      pin_sync  <= {pin_sync[0], init_done_in};
    end
  end

  // ***************************************************
  // Initialization timing
  // ***************************************************
  assign init_tick = opt[`OCP_BIT_USRCLK_EN] ? (uclk_sync[1] & ~uclk_sync[2]) : 1'b1;
  assign init_end  = init_tick && (ticks == INIT_TICKS - 8'h01);
  assign chip_tri  = opt[`OCP_BIT_OE_EN] & ~oe_sync[1];
  assign chip_clr  = opt[`OCP_BIT_CLR_EN] & ~clr_sync[1];

  always @(posedge clk_in) begin
    if (rst_in || state != ST_INIT) begin
      ticks <= 8'h00;
    end else if (init_tick) begin
      ticks <= ticks + 8'h01;
    end
  end

  // ***************************************************
  // Configuration sequence
  // ***************************************************
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (rst_sync[1]) begin
          next_state = ST_CFG;
        end
      end
      ST_CFG: begin
        if (ev_frame) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (ev_loaded) begin
          next_state = ST_INIT;
        end
      end
      ST_INIT: begin
        if (init_end) begin
          next_state = opt[`OCP_BIT_OCT_GATE] ? ST_OCT : ST_USER;
        end
      end
      ST_OCT: begin
        if (cal_sync[1]) begin
          next_state = ST_USER;
        end
      end
      ST_USER: begin
        next_state = ST_USER;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (!rst_sync[1]) begin
      next_state = ST_IDLE;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      opt   <= 6'h00;
    end else begin
      state <= next_state;
      if (!rst_sync[1]) begin
        opt <= 6'h00;
      end else if (state == ST_CFG && ev_frame) begin
        opt <= ctrl[5:0];
      end
    end
  end

  // ***************************************************
  // Pin drivers
  // ***************************************************
  assign drive_low = opt[`OCP_BIT_INIT_EN] &&
                     (state == ST_LOAD || state == ST_INIT || state == ST_OCT);

  always @(posedge clk_in) begin
    if (rst_in) begin
      init_done_out            <= 1'b0;
      init_done_oe_out         <= 1'b0;
      init_done_pullup_out     <= 1'b1;
      io_tristate_out          <= 1'b0;
      reg_clear_out            <= 1'b0;
      serial_pins_tristate_out <= 1'b0;
      user_mode_out            <= 1'b0;
    end else begin
      io_tristate_out <= chip_tri;
      reg_clear_out   <= chip_clr;
      user_mode_out   <= (next_state == ST_USER);
      serial_pins_tristate_out <= (next_state == ST_USER) && opt[`OCP_BIT_AS_TRI];
      if (opt[`OCP_BIT_INIT_EN] || state != ST_USER) begin
        init_done_out        <= 1'b0;
        init_done_pullup_out <= !opt[`OCP_BIT_INIT_EN];
        init_done_oe_out     <= drive_low;
      end else begin
        init_done_out        <= ctrl[`OCP_BIT_UIO_OUT];
        init_done_pullup_out <= 1'b0;
        init_done_oe_out     <= ctrl[`OCP_BIT_UIO_OE] && !chip_tri;
      end
    end
  end

  // ***************************************************
  // AXI4-Lite write path
  // ***************************************************
  assign wr_go   = (aw_held || s_axi_awvalid_in) && (w_held || s_axi_wvalid_in) &&
                   !s_axi_bvalid_out;
  assign wr_addr = aw_held ? aw_addr : s_axi_awaddr_in;
  assign wr_data = w_held ? w_data : s_axi_wdata_in;
  assign wr_strb = w_held ? w_strb : s_axi_wstrb_in;
  assign wr_masked = wr_data[9:0] & `OCP_CTRL_MASK;

  always @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `OCP_RESP_OKAY;
      aw_held           <= 1'b0;
      aw_addr           <= 4'h0;
      w_held            <= 1'b0;
      w_data            <= 32'h0000_0000;
      w_strb            <= 4'h0;
      ctrl              <= `OCP_CTRL_RESET;
      ev_frame          <= 1'b0;
      ev_loaded         <= 1'b0;
    end else begin
      ev_frame  <= 1'b0;
      ev_loaded <= 1'b0;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      s_axi_awready_out <= !aw_held && !(s_axi_awvalid_in && s_axi_awready_out) &&
                           !wr_go && !s_axi_bvalid_out;
      s_axi_wready_out  <= !w_held && !(s_axi_wvalid_in && s_axi_wready_out) &&
                           !wr_go && !s_axi_bvalid_out;
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
      if (aw_held && w_held && !s_axi_bvalid_out) begin
        aw_held          <= 1'b0;
        w_held           <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= `OCP_RESP_OKAY;
        if (wr_addr == `OCP_ADDR_CTRL) begin
          if (wr_strb[0]) begin
            ctrl[7:0] <= wr_masked[7:0];
          end
          if (wr_strb[1]) begin
            ctrl[9:8] <= wr_masked[9:8];
          end
        end else if (wr_addr == `OCP_ADDR_CFG) begin
          ev_frame  <= wr_strb[0] & wr_data[`OCP_BIT_FRAME];
          ev_loaded <= wr_strb[0] & wr_data[`OCP_BIT_LOADED];
        end else if (wr_addr != `OCP_ADDR_STATUS) begin
          s_axi_bresp_out <= `OCP_RESP_DECERR;
        end
      end
      if (chip_clr) begin
        ctrl[9:8] <= 2'h0;
      end
    end
  end

  // ***************************************************
  // AXI4-Lite read path
  // ***************************************************
  always @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= `OCP_RESP_OKAY;
    end else begin
      s_axi_arready_out <= !s_axi_rvalid_out && !(s_axi_arvalid_in && s_axi_arready_out);
      if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out  <= `OCP_RESP_OKAY;
        s_axi_rdata_out  <= 32'h0000_0000;
        if (s_axi_araddr_in == `OCP_ADDR_CTRL) begin
          s_axi_rdata_out <= {22'h000000, ctrl};
        end else if (s_axi_araddr_in == `OCP_ADDR_STATUS) begin
          s_axi_rdata_out <= {19'h00000, state == ST_USER, clr_sync[1], oe_sync[1],
                              cal_sync[1], rst_sync[1], pin_sync[1], opt[0], state};
        end else if (s_axi_araddr_in != `OCP_ADDR_CFG) begin
          s_axi_rresp_out <= `OCP_RESP_DECERR;
        end
      end
    end
  end
endmodule

/* File: sim/ocp_checker.sv */
// Concurrent checks on the option pin block ports
module ocp_checker (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Bus responses
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Pins
  input wire logic config_restart_n_in,
  input wire logic chip_output_enable_in,
  input wire logic chip_register_clear_n_in,
  input wire logic init_done_out,
  input wire logic init_done_oe_out,
  input wire logic init_done_pullup_out,
  // Chip-wide controls
  input wire logic io_tristate_out,
  input wire logic reg_clear_out,
  input wire logic serial_pins_tristate_out,
  input wire logic user_mode_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ***************************************************
  // Assertions
  // ***************************************************
  a_restart_idle: assert property (!config_restart_n_in [*6] |->
    !init_done_oe_out && !user_mode_out)
    else $error("completion pin or user mode active in restart");
  a_drive_low: assert property (init_done_oe_out && !user_mode_out &&
    !$past(user_mode_out) |-> !init_done_out)
    else $error("completion pin driven high");
  a_pullup_off: assert property (init_done_oe_out |-> !init_done_pullup_out)
    else $error("pull-up on while pin driven");
  a_user_release: assert property ($rose(user_mode_out) && init_done_oe_out
    |=> !init_done_oe_out)
    else $error("completion pin held in user mode");
  a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out)
    else $error("read data dropped");
  a_oe_high: assert property (chip_output_enable_in [*6] ##0 user_mode_out
    |-> !io_tristate_out)
    else $error("outputs tristated with enable high");
  a_clr_high: assert property (chip_register_clear_n_in [*6] |-> !reg_clear_out)
    else $error("registers cleared with clear high");
  a_sync_oe: assert property ($changed(chip_output_enable_in) |=>
    $stable(io_tristate_out) [*2])
    else $error("output enable used unsynchronized");
  a_serial_user: assert property ($rose(serial_pins_tristate_out) |-> user_mode_out)
    else $error("serial pins tristated before user mode");
  c_user: cover property ($rose(user_mode_out));
  c_iotri: cover property ($rose(io_tristate_out));
  c_clear: cover property ($rose(reg_clear_out));
endmodule

/* File: sim/ocp_board_mon.sv */
// Board monitor model: completion pin pull-up, edge watcher, start-up clock
module ocp_board_mon (
  // Clock
  input wire logic clk_in,
  // Completion pin from the device
  input wire logic pin_drive_in,
  input wire logic pin_oe_in,
  // Start-up clock control
  input wire logic clock_run_in,
  // Board side
  output logic     pin_level_out,
  output logic     user_clock_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       last_level = 1'b1;
  logic [1:0] div = 2'h0;
  int         rise_count = 0;
  initial user_clock_out = 1'b0;
  // External pull-up resolves the open-drain pin
  assign pin_level_out = pin_oe_in ? pin_drive_in : 1'b1;
  always @(posedge clk_in) begin
    last_level <= pin_level_out;
    if (pin_level_out && !last_level) rise_count <= rise_count + 1;
    div <= clock_run_in ? div + 2'h1 : 2'h0;
    if (clock_run_in && div == 2'h3) user_clock_out <= !user_clock_out;
  end
endmodule

/* File: sim/optional_config_pin_control_tb.sv */
// Testbench for the option pin block
`include "ocp_regs.vh"
module optional_config_pin_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in, rst_in, awvalid, wvalid, bready, arvalid, rready;
  logic        restart_n, cal, oe_pin, clr_n, run;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rd;
  wire         awready, wready, bvalid, arready, rvalid, pin, uclk;
  wire         oe, od, pu, iot, rclr, stri, umode;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  int          err_count, checks;
  ocp_top #(.INIT_TICKS(8'h04)) dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .config_restart_n_in(restart_n), .user_startup_clock_in(uclk),
    .termination_cal_done_in(cal), .chip_output_enable_in(oe_pin),
    .chip_register_clear_n_in(clr_n), .init_done_in(pin), .init_done_out(od),
    .init_done_oe_out(oe), .init_done_pullup_out(pu), .io_tristate_out(iot),
    .reg_clear_out(rclr), .serial_pins_tristate_out(stri), .user_mode_out(umode));
  ocp_board_mon mon_u (.clk_in(clk_in), .pin_drive_in(od), .pin_oe_in(oe),
    .clock_run_in(run), .pin_level_out(pin), .user_clock_out(uclk));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task finish_test;
    $display("Checks %0d, errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ***************************************************
  // Bus tasks
  // ***************************************************
  task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    chk({bvalid, bresp}, {1'b1, r});
    @(posedge clk_in);
  endtask
  task axi_rd(input logic [3:0] a, input logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    rd = rdata;
    chk({rvalid, rresp}, {1'b1, r});
    @(posedge clk_in);
  endtask
  // ***************************************************
  // Scenarios
  // ***************************************************
  task t_regs;
    axi_rd(`OCP_ADDR_CTRL, `OCP_RESP_OKAY);
    chk(rd, 32'h0);
    axi_wr(`OCP_ADDR_CTRL, 32'hFFFFFFFF, `OCP_RESP_OKAY);
    axi_rd(`OCP_ADDR_CTRL, `OCP_RESP_OKAY);
    chk(rd, {22'h0, `OCP_CTRL_MASK});
    axi_wr(`OCP_ADDR_STATUS, 32'hFFFFFFFF, `OCP_RESP_OKAY);
    axi_wr(4'hC, 32'h1, `OCP_RESP_DECERR);
    axi_rd(4'hC, `OCP_RESP_DECERR);
    $display("Test registers done");
  endtask
  task t_boot(input logic [9:0] c, input logic stall);
    int base;
    base = mon_u.rise_count;
    cal <= !stall;
    run <= !stall;
    axi_wr(`OCP_ADDR_CTRL, {22'h0, c}, `OCP_RESP_OKAY);
    restart_n <= 1'b0;
    repeat (20) @(posedge clk_in);
    restart_n <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk(oe, 1'b0);
    axi_wr(`OCP_ADDR_CFG, 32'h1, `OCP_RESP_OKAY);
    repeat (3) @(posedge clk_in);
    chk({oe, od, pu}, {c[1], 1'b0, !c[1]});
    axi_wr(`OCP_ADDR_CFG, 32'h2, `OCP_RESP_OKAY);
    if (stall) begin
      repeat (60) @(posedge clk_in);
      chk({umode, oe}, {!(c[0] | c[2]), c[1] & (c[0] | c[2])});
      cal <= 1'b1;
      run <= 1'b1;
    end
    for (int n = 0; n < 300 && umode !== 1'b1; n++) @(posedge clk_in);
    repeat (2) @(posedge clk_in);
    chk({umode, oe, pin, stri}, {1'b1, c[9] & !c[1], c[8] | !c[9] | c[1], c[5]});
    chk(od, c[8] & !c[1]);
    chk(mon_u.rise_count - base, c[1]);
    axi_rd(`OCP_ADDR_STATUS, `OCP_RESP_OKAY);
    chk({rd[12], rd[5:0]}, 7'h60);
    $display("Test boot %h done", c);
  endtask
  task t_chip;
    t_boot(10'h33A, 1'b0);
    oe_pin <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk(iot, 1'b1);
    oe_pin <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk(iot, 1'b0);
    clr_n <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk(rclr, 1'b1);
    clr_n <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk(rclr, 1'b0);
    axi_rd(`OCP_ADDR_CTRL, `OCP_RESP_OKAY);
    chk(rd, 32'h03A);
    $display("Test chip controls done");
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {rst_in, restart_n, cal, oe_pin, clr_n, run} = 6'h3F;
    err_count = 0;
    checks = 0;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_regs;
    t_boot(10'h002, 1'b0);
    t_boot(10'h002, 1'b1);
    t_boot(10'h006, 1'b1);
    t_boot(10'h003, 1'b1);
    t_boot(10'h300, 1'b0);
    t_chip;
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    finish_test;
  end
endmodule
bind ocp_top ocp_checker chk_u (.clk_in(clk_in), .rst_in(rst_in),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
  .config_restart_n_in(config_restart_n_in), .chip_output_enable_in(chip_output_enable_in),
  .chip_register_clear_n_in(chip_register_clear_n_in), .init_done_out(init_done_out),
  .init_done_oe_out(init_done_oe_out), .init_done_pullup_out(init_done_pullup_out),
  .io_tristate_out(io_tristate_out), .reg_clear_out(reg_clear_out),
  .serial_pins_tristate_out(serial_pins_tristate_out), .user_mode_out(user_mode_out));
